// [rtl/rtc_top.sv]
/*
 * Receive-side test and observation block of a multi-lane serial data
 * port: transport sample check, logical lane inversion and the paged
 * capture of the lane 0 alignment configuration, behind an APB slave.
 * Assumes one clock for bus and link logic, and that the deframer gives
 * a tagged sample stream and a one-cycle capture strobe with octets.
 */
// Contract
// - A 4-bit sample index picks sample 0 to 15 for the check.
// - A 2-bit field picks subchannel 0, 1 or 2 for the check.
// - Writing one to the clear bit clears the result; zero does not.
// - The comparison runs only while the enable bit is one.
// - Two bytes form a 16-bit reference compared to the sample.
// - A link bit picks link 0 or link 1 samples for the check.
// - A path bit picks I or Q; software picks I for real data.
// - A read-only flag is zero on a match and one on a mismatch.
// - Bit x of the invert mask inverts logical lane x data.
// - Device, bank, adjust, phase and lane count are captured.
// - The 5-bit lane identifier of lane 0 is captured.
// - Captures are banked per link, read through the page bit.
// - The captured 3-bit version tells earlier from current.
`timescale 1ns/10ps
module rtc_top (
	input  wire logic                                      clk,
	input  wire logic                                      rst_n,
	input  wire logic [rtc_pkg::ADDR_W-1:0]                paddr,
	input  wire logic                                      psel,
	input  wire logic                                      penable,
	input  wire logic                                      pwrite,
	input  wire logic [rtc_pkg::DATA_W-1:0]                pwdata,
	input  wire logic [3:0]                                pstrb,
	output logic      [rtc_pkg::DATA_W-1:0]                prdata,
	output logic                                           pready,
	output logic                                           pslverr,
	input  wire logic [rtc_pkg::LANES-1:0][rtc_pkg::LANE_W-1:0] lane_data_in,
	output logic      [rtc_pkg::LANES-1:0][rtc_pkg::LANE_W-1:0] lane_data_out,
	input  wire logic                                      sample_valid,
	input  wire logic                                      sample_link,
	input  wire logic                                      sample_path,
	input  wire logic [rtc_pkg::CHAN_W-1:0]                sample_chan,
	input  wire logic [rtc_pkg::INDEX_W-1:0]               sample_index,
	input  wire logic [rtc_pkg::SAMPLE_W-1:0]              sample_data,
	input  wire logic                                      ilas_valid,
	input  wire logic                                      ilas_link,
	input  wire logic [rtc_pkg::OCTETS-1:0][rtc_pkg::REG_W-1:0] ilas_octets
);

	// ==========================================================================
	// State of the block

	// All registers of the block except the checker's sticky flag live in this one record.
	typedef struct packed {
		logic                                           link_page;
		logic [rtc_pkg::REG_W-1:0]                      ctrl;
		logic [rtc_pkg::REG_W-1:0]                      ref_low;
		logic [rtc_pkg::REG_W-1:0]                      ref_high;
		logic                                           link_sel;
		logic                                           path_sel;
		logic [rtc_pkg::REG_W-1:0]                      invert_mask;
		logic                                           clear_pulse;
		rtc_pkg::rtc_ilas_t [rtc_pkg::LINKS-1:0]        ilas;
		logic                                           pready;
		logic                                           pslverr;
		logic [rtc_pkg::DATA_W-1:0]                     prdata;
		logic [rtc_pkg::LANES-1:0][rtc_pkg::LANE_W-1:0] lane_out;
	} rtc_state_t;

	rtc_state_t                  q;
	rtc_state_t                  d;
	logic                        access;
	logic                        addr_ok;
	logic [rtc_pkg::IDX_W-1:0]   idx;
	logic                        mismatch;

	rtc_check_if chk_bus ();

	// ==========================================================================
	// Address decode helpers

	// A register is addressed only by an aligned word inside the map.
	function automatic logic aligned_in_map(
		input logic [rtc_pkg::ADDR_W-1:0] a
	);
		logic [rtc_pkg::ADDR_W-1:0] spill;
		spill = a >> (rtc_pkg::IDX_W + rtc_pkg::IDX_LSB);
		return (spill == '0) && (a[rtc_pkg::IDX_LSB-1:0] == '0);
	endfunction : aligned_in_map

	// Turns a byte address into the register index.
	function automatic logic [rtc_pkg::IDX_W-1:0] reg_index(
		input logic [rtc_pkg::ADDR_W-1:0] a
	);
		return a[rtc_pkg::IDX_W+rtc_pkg::IDX_LSB-1:rtc_pkg::IDX_LSB];
	endfunction : reg_index

	// Tells whether an index names a register of this block.
	function automatic logic is_mapped(
		input logic [rtc_pkg::IDX_W-1:0] i
	);
		unique case (i)
			rtc_pkg::IDX_LINK_PAGE,
			rtc_pkg::IDX_CHECK_CTRL,
			rtc_pkg::IDX_REF_LOW,
			rtc_pkg::IDX_REF_HIGH,
			rtc_pkg::IDX_SEL_RESULT,
			rtc_pkg::IDX_LANE_INV,
			rtc_pkg::IDX_DEV_ID,
			rtc_pkg::IDX_BANK_ID,
			rtc_pkg::IDX_LANE_ADJ,
			rtc_pkg::IDX_SCR_LANES,
			rtc_pkg::IDX_VERSION: begin
				return 1'b1;
			end
			default: begin
				return 1'b0;
			end
		endcase
	endfunction : is_mapped

	// Forms the read image of one register; reserved bits read as zero.
	function automatic logic [rtc_pkg::REG_W-1:0] read_image(
		input logic [rtc_pkg::IDX_W-1:0] i,
		input rtc_state_t                s,
		input logic                      fail
	);
		logic [rtc_pkg::REG_W-1:0] v;
		rtc_pkg::rtc_ilas_t        page;
		v    = '0;
		page = s.ilas[s.link_page];
		unique case (i)
			rtc_pkg::IDX_LINK_PAGE: begin
				v[rtc_pkg::PAGE_BIT] = s.link_page;
			end
			rtc_pkg::IDX_CHECK_CTRL: begin
				v = s.ctrl;
			end
			rtc_pkg::IDX_REF_LOW: begin
				v = s.ref_low;
			end
			rtc_pkg::IDX_REF_HIGH: begin
				v = s.ref_high;
			end
			rtc_pkg::IDX_SEL_RESULT: begin
				v[rtc_pkg::SEL_LINK_BIT] = s.link_sel;
				v[rtc_pkg::SEL_PATH_BIT] = s.path_sel;
				v[rtc_pkg::SEL_FAIL_BIT] = fail;
			end
			rtc_pkg::IDX_LANE_INV: begin
				v = s.invert_mask;
			end
			rtc_pkg::IDX_DEV_ID: begin
				v = page.dev_id;
			end
			rtc_pkg::IDX_BANK_ID: begin
				v = page.bank_id;
			end
			rtc_pkg::IDX_LANE_ADJ: begin
				v = page.lane_adj;
			end
			rtc_pkg::IDX_SCR_LANES: begin
				v = page.scr_lanes;
			end
			rtc_pkg::IDX_VERSION: begin
				v = page.version;
			end
			default: begin
				v = '0;
			end
		endcase
		return v;
	endfunction : read_image

	// Builds the register images of one alignment capture.
	function automatic rtc_pkg::rtc_ilas_t capture(
		input logic [rtc_pkg::OCTETS-1:0][rtc_pkg::REG_W-1:0] o
	);
		rtc_pkg::rtc_ilas_t c;
		c           = '0;
		c.dev_id    = o[rtc_pkg::OCT_DID];
		c.bank_id[rtc_pkg::BID_W-1:0] =
			o[rtc_pkg::OCT_BID][rtc_pkg::BID_W-1:0];
		c.lane_adj[rtc_pkg::ADJDIR_BIT] =
			o[rtc_pkg::OCT_LID][rtc_pkg::ADJDIR_BIT];
		c.lane_adj[rtc_pkg::PHADJ_BIT] =
			o[rtc_pkg::OCT_LID][rtc_pkg::PHADJ_BIT];
		c.lane_adj[rtc_pkg::LID_W-1:0] =
			o[rtc_pkg::OCT_LID][rtc_pkg::LID_W-1:0];
		c.scr_lanes[rtc_pkg::SCR_BIT] =
			o[rtc_pkg::OCT_SCR_L][rtc_pkg::SCR_BIT];
		c.scr_lanes[rtc_pkg::LCNT_W-1:0] =
			o[rtc_pkg::OCT_SCR_L][rtc_pkg::LCNT_W-1:0];
		c.version[rtc_pkg::VER_LSB+rtc_pkg::VER_W-1:rtc_pkg::VER_LSB] =
			o[rtc_pkg::OCT_VER][rtc_pkg::VER_LSB+rtc_pkg::VER_W-1:
			rtc_pkg::VER_LSB];
		return c;
	endfunction : capture

	// ==========================================================================
	// Bus decode

	// An access phase is under way while select and enable are both high.
	assign access  = psel && penable;
	assign addr_ok = aligned_in_map(paddr);
	assign idx     = reg_index(paddr);

	// ==========================================================================
	// Next state

	// Bus slave, control writes, lane inversion and capture in one pass.
	always_comb begin
		d             = q;
		d.clear_pulse = 1'b0;

		// Each access waits one cycle so that read data comes from a flop.
		if (access && !q.pready) begin
			d.pready  = 1'b1;
			d.pslverr = !(addr_ok && is_mapped(idx));
			d.prdata  = '0;
			if (addr_ok && !pwrite) begin
				d.prdata[rtc_pkg::REG_W-1:0] = read_image(idx, q, mismatch);
			end
		end else begin
			d.pready  = 1'b0;
			d.pslverr = 1'b0;
		end

		// Writes land on the edge where pready is seen high.
		if (access && q.pready && pwrite && pstrb[0] && addr_ok) begin
			unique case (idx)
				rtc_pkg::IDX_LINK_PAGE: begin
					d.link_page = pwdata[rtc_pkg::PAGE_BIT];
				end
				rtc_pkg::IDX_CHECK_CTRL: begin
					d.ctrl = pwdata[rtc_pkg::REG_W-1:0];
					// Only a one in the clear bit fires the clear.
					d.clear_pulse = pwdata[rtc_pkg::CTRL_CLEAR_BIT];
				end
				rtc_pkg::IDX_REF_LOW: begin
					d.ref_low = pwdata[rtc_pkg::REG_W-1:0];
				end
				rtc_pkg::IDX_REF_HIGH: begin
					d.ref_high = pwdata[rtc_pkg::REG_W-1:0];
				end
				rtc_pkg::IDX_SEL_RESULT: begin
					d.link_sel = pwdata[rtc_pkg::SEL_LINK_BIT];
					d.path_sel = pwdata[rtc_pkg::SEL_PATH_BIT];
				end
				rtc_pkg::IDX_LANE_INV: begin
					d.invert_mask = pwdata[rtc_pkg::REG_W-1:0];
				end
				default: begin
					// Read-only and unmapped words ignore writes.
				end
			endcase
		end

		// Each logical lane is inverted on its own mask bit.
		for (int i = 0; i < rtc_pkg::LANES; i++) begin
			d.lane_out[i] = lane_data_in[i]
				^ {rtc_pkg::LANE_W{q.invert_mask[i]}};
		end

		// A capture strobe overwrites the bank of the announcing link.
		if (ilas_valid) begin
			d.ilas[ilas_link] = capture(ilas_octets);
		end
	end

	// ==========================================================================
	// Registers

	// One register stage for the whole record; all fields reset to zero.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ==========================================================================
	// Checker connection

	// Setup fields and the sample stream feed the checker.
	assign chk_bus.enable    = q.ctrl[rtc_pkg::CTRL_EN_BIT];
	assign chk_bus.clear     = q.clear_pulse;
	assign chk_bus.link_sel  = q.link_sel;
	assign chk_bus.path_sel  = q.path_sel;
	assign chk_bus.chan_sel  =
		q.ctrl[rtc_pkg::CTRL_CHAN_LSB+rtc_pkg::CHAN_W-1:
		rtc_pkg::CTRL_CHAN_LSB];
	assign chk_bus.index_sel =
		q.ctrl[rtc_pkg::CTRL_INDEX_LSB+rtc_pkg::INDEX_W-1:
		rtc_pkg::CTRL_INDEX_LSB];
	assign chk_bus.expected  = {q.ref_high, q.ref_low};
	assign chk_bus.s_valid   = sample_valid;
	assign chk_bus.s_link    = sample_link;
	assign chk_bus.s_path    = sample_path;
	assign chk_bus.s_chan    = sample_chan;
	assign chk_bus.s_index   = sample_index;
	assign chk_bus.s_data    = sample_data;
	assign mismatch          = chk_bus.mismatch;

	// The comparison itself and its sticky result.
	rtc_sample_check u_check (
		.clk   (clk),
		.rst_n (rst_n),
		.chk   (chk_bus.chk)
	);

	// ==========================================================================
	// Outputs

	// Bus answers and inverted lanes all come straight from flops.
	assign pready        = q.pready;
	assign pslverr       = q.pslverr;
	assign prdata        = q.prdata;
	assign lane_data_out = q.lane_out;

endmodule : rtc_top

// [rtl/rtc_pkg.sv]
/*
 * Constants shared by the receive-side test and capture logic: register
 * indices, field positions, widths and capture octet positions.
 * Assumes nothing of its surroundings; it holds definitions only.
 */
package rtc_pkg;

	// ==========================================================================
	// Bus and datapath widths
	localparam int unsigned ADDR_W     = 16;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned REG_W      = 8;
	localparam int unsigned IDX_W      = 12;
	localparam int unsigned IDX_LSB    = 2;
	localparam int unsigned LANES      = 8;
	localparam int unsigned LANE_W     = 32;
	localparam int unsigned SAMPLE_W   = 16;
	localparam int unsigned INDEX_W    = 4;
	localparam int unsigned CHAN_W     = 2;
	localparam int unsigned OCTETS     = 10;
	localparam int unsigned LINKS      = 2;

	// ==========================================================================
	// Register indices; the byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_LINK_PAGE  = 12'h300;
	localparam logic [IDX_W-1:0] IDX_CHECK_CTRL = 12'h32c;
	localparam logic [IDX_W-1:0] IDX_REF_LOW    = 12'h32d;
	localparam logic [IDX_W-1:0] IDX_REF_HIGH   = 12'h32e;
	localparam logic [IDX_W-1:0] IDX_SEL_RESULT = 12'h32f;
	localparam logic [IDX_W-1:0] IDX_LANE_INV   = 12'h334;
	localparam logic [IDX_W-1:0] IDX_DEV_ID     = 12'h400;
	localparam logic [IDX_W-1:0] IDX_BANK_ID    = 12'h401;
	localparam logic [IDX_W-1:0] IDX_LANE_ADJ   = 12'h402;
	localparam logic [IDX_W-1:0] IDX_SCR_LANES  = 12'h403;
	localparam logic [IDX_W-1:0] IDX_VERSION    = 12'h409;

	// ==========================================================================
	// Field positions inside the registers
	localparam int unsigned CTRL_INDEX_LSB = 4;
	localparam int unsigned CTRL_CHAN_LSB  = 2;
	localparam int unsigned CTRL_CLEAR_BIT = 1;
	localparam int unsigned CTRL_EN_BIT    = 0;
	localparam int unsigned SEL_LINK_BIT   = 7;
	localparam int unsigned SEL_PATH_BIT   = 6;
	localparam int unsigned SEL_FAIL_BIT   = 0;
	localparam int unsigned PAGE_BIT       = 0;
	localparam int unsigned ADJDIR_BIT     = 6;
	localparam int unsigned PHADJ_BIT      = 5;
	localparam int unsigned LID_W          = 5;
	localparam int unsigned BID_W          = 4;
	localparam int unsigned SCR_BIT        = 7;
	localparam int unsigned LCNT_W         = 5;
	localparam int unsigned VER_LSB        = 5;
	localparam int unsigned VER_W          = 3;

	// ==========================================================================
	// Positions of the captured octets in the alignment configuration
	localparam int unsigned OCT_DID   = 0;
	localparam int unsigned OCT_BID   = 1;
	localparam int unsigned OCT_LID   = 2;
	localparam int unsigned OCT_SCR_L = 3;
	localparam int unsigned OCT_VER   = 9;

	// Protocol version codes as announced by the transmitter.
	localparam logic [VER_W-1:0] VER_EARLIER = 3'h0;
	localparam logic [VER_W-1:0] VER_CURRENT = 3'h1;

	// Captured configuration of one link, kept as register images.
	typedef struct packed {
		logic [REG_W-1:0] dev_id;
		logic [REG_W-1:0] bank_id;
		logic [REG_W-1:0] lane_adj;
		logic [REG_W-1:0] scr_lanes;
		logic [REG_W-1:0] version;
	} rtc_ilas_t;

endpackage : rtc_pkg

// [rtl/rtc_check_if.sv]
/*
 * Carrier between the register block and the sample checker: selection,
 * reference, clear, the tagged sample stream and the result flag.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface rtc_check_if;
	logic                          enable;
	logic                          clear;
	logic                          link_sel;
	logic                          path_sel;
	logic [rtc_pkg::CHAN_W-1:0]    chan_sel;
	logic [rtc_pkg::INDEX_W-1:0]   index_sel;
	logic [rtc_pkg::SAMPLE_W-1:0]  expected;
	logic                          s_valid;
	logic                          s_link;
	logic                          s_path;
	logic [rtc_pkg::CHAN_W-1:0]    s_chan;
	logic [rtc_pkg::INDEX_W-1:0]   s_index;
	logic [rtc_pkg::SAMPLE_W-1:0]  s_data;
	logic                          mismatch;

	// The register side drives the setup and samples; the checker answers.
	modport ctl (output enable, clear, link_sel, path_sel, chan_sel,
		index_sel, expected, s_valid, s_link, s_path, s_chan, s_index,
		s_data, input mismatch);
	modport chk (input enable, clear, link_sel, path_sel, chan_sel,
		index_sel, expected, s_valid, s_link, s_path, s_chan, s_index,
		s_data, output mismatch);
endinterface : rtc_check_if

// [rtl/rtc_sample_check.sv]
/*
 * Transport sample checker: compares the selected received sample with
 * the software reference and keeps a sticky mismatch flag.
 * Assumes the sample stream is tagged with link, path, subchannel and
 * sample index, on the same clock as the register block.
 */
`timescale 1ns/10ps
module rtc_sample_check (
	input  wire logic  clk,
	input  wire logic  rst_n,
	rtc_check_if.chk   chk
);

	// ==========================================================================
	// State
	typedef struct packed {
		logic mismatch;
	} rtc_chk_state_t;

	rtc_chk_state_t q;
	rtc_chk_state_t d;
	logic           selected;

	// Picks out the one sample position that software asked for.
	assign selected = chk.enable && chk.s_valid
		&& (chk.s_link == chk.link_sel)
		&& (chk.s_path == chk.path_sel)
		&& (chk.s_chan == chk.chan_sel)
		&& (chk.s_index == chk.index_sel);

	// Sets on a differing sample; a set in the clear cycle wins the clear.
	always_comb begin
		d = q;
		if (selected && (chk.s_data != chk.expected)) begin
			d.mismatch = 1'b1;
		end else if (chk.clear) begin
			d.mismatch = 1'b0;
		end
	end

	// Holds the flag while disabled; only the clear or a reset brings it back.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign chk.mismatch = q.mismatch;

endmodule : rtc_sample_check

// [testbench/rtc_top_assertions.sv]
/*
 * Checker for rtc_top: APB answer timing, error answers, lane inversion.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
module rtc_top_assertions (
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire logic [15:0]           paddr,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [31:0]           pwdata,
	input wire logic [3:0]            pstrb,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic [7:0][31:0]      lane_data_in,
	input wire logic [7:0][31:0]      lane_data_out
);
	// ==========================================================
	// Helper copy of the invert mask and the expected lane data.
	logic             acc;
	logic             wr_inv;
	logic [7:0]       mask_q;
	logic [7:0][31:0] exp_q;

	assign acc = psel && penable && !pready;
	assign wr_inv = psel && penable && pready && pwrite && pstrb[0];

	// The mask follows completed writes to the invert register.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mask_q <= 8'h00;
			exp_q  <= '0;
		end else begin
			if (wr_inv && paddr == 16'h0cd0) begin
				mask_q <= pwdata[7:0];
			end
			for (int k = 0; k < 8; k++) begin
				exp_q[k] <= lane_data_in[k] ^ {32{mask_q[k]}};
			end
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_rdy; acc |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready after access");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("ready too long");
	property p_cause; pready |-> $past(acc); endproperty
	a_cause: assert property (p_cause) else $error("ready without access");
	property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("bad error answer");
	property p_unal; acc && paddr[1:0] != 2'h0 |=> pslverr; endproperty
	a_unal: assert property (p_unal) else $error("unaligned not refused");
	property p_rdhi; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
	a_rdhi: assert property (p_rdhi) else $error("read upper bits set");
	property p_wr0; pready && pwrite |-> prdata == 32'h0; endproperty
	a_wr0: assert property (p_wr0) else $error("write returned data");
	property p_ro; acc && paddr == 16'h1000 |=> !pslverr; endproperty
	a_ro: assert property (p_ro) else $error("read-only refused");
	property p_inv; lane_data_out == exp_q; endproperty
	a_inv: assert property (p_inv) else $error("lane inversion");
endmodule : rtc_top_assertions

bind rtc_top rtc_top_assertions i_rtc_top_assertions (.clk(clk),
	.rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .lane_data_in(lane_data_in),
	.lane_data_out(lane_data_out));

// [testbench/rtc_tx_model.sv]
/*
 * Far-side transmitter model: free-running lane data, tagged samples
 * and alignment configuration strobes.
 * Assumes the bench calls its tasks; all outputs move at rising edges.
 */
`timescale 1ns/10ps
module rtc_tx_model (
	input wire logic        clk,
	output logic [7:0][31:0] lane_data,
	output logic            s_valid,
	output logic            s_link,
	output logic            s_path,
	output logic [1:0]      s_chan,
	output logic [3:0]      s_index,
	output logic [15:0]     s_data,
	output logic            i_valid,
	output logic            i_link,
	output logic [9:0][7:0] i_oct
);
	integer seed = 37;

	// ==========================================================
	// Lane data changes every cycle, as a live link would.
	initial begin
		{s_valid, s_link, s_path, s_chan, s_index, s_data} = '0;
		{i_valid, i_link, i_oct, lane_data} = '0;
	end
	always @(posedge clk) begin
		for (int k = 0; k < 8; k++) begin
			lane_data[k] <= $random(seed);
		end
	end

	// One tagged sample; afterwards the lines show inverted values.
	task send(input logic l, p, input logic [1:0] c, input logic [3:0] i,
		input logic [15:0] d);
		@(posedge clk);
		{s_valid, s_link, s_path, s_chan, s_index, s_data} <= {1'b1, l, p, c, i, d};
		@(posedge clk);
		{s_valid, s_link, s_path, s_chan, s_index, s_data} <= {1'b0, ~l, ~p, ~c, ~i, ~d};
	endtask : send

	// One alignment configuration, octet k in slot k.
	task send_ilas(input logic l, input logic [9:0][7:0] o);
		@(posedge clk);
		{i_valid, i_link, i_oct} <= {1'b1, l, o};
		@(posedge clk);
		{i_valid, i_link, i_oct} <= {1'b0, ~l, ~o};
	endtask : send_ilas
endmodule : rtc_tx_model

// [testbench/rtc_top_tb.sv]
/*
 * Self-checking bench for rtc_top: register map, sample check and
 * alignment capture through APB, lane inversion at the lane ports.
 * Assumes the model rtc_tx_model and the bound checker.
 */
`timescale 1ns/10ps
module rtc_top_tb;
	logic             clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [15:0]      paddr;
	logic [31:0]      pwdata, prdata, rd;
	logic [3:0]       pstrb;
	logic [7:0][31:0] lane_in, lane_out, li;
	logic             s_valid, s_link, s_path, i_valid, i_link, l, p, er;
	logic [1:0]       s_chan, c;
	logic [3:0]       s_index;
	logic [15:0]      s_data, r16;
	logic [9:0][7:0]  oct;
	logic [9:0][7:0]  capt [2];
	logic [7:0]       m;
	logic [11:0]      rw_idx [6];
	logic [7:0]       rw_msk [6];
	logic [11:0]      cap_idx [5];
	int               mismatches, tests_run, k, j;
	integer           seed;

	rtc_top i_rtc_top (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.lane_data_in(lane_in), .lane_data_out(lane_out),
		.sample_valid(s_valid), .sample_link(s_link), .sample_path(s_path),
		.sample_chan(s_chan), .sample_index(s_index), .sample_data(s_data),
		.ilas_valid(i_valid), .ilas_link(i_link), .ilas_octets(oct));
	rtc_tx_model i_rtc_tx_model (.clk(clk), .lane_data(lane_in),
		.s_valid(s_valid), .s_link(s_link), .s_path(s_path), .s_chan(s_chan),
		.s_index(s_index), .s_data(s_data), .i_valid(i_valid),
		.i_link(i_link), .i_oct(oct));

	// ==========================================================
	// Clock, expectations and bus tasks.
	always #50 clk = ~clk;

	function automatic logic [15:0] ad(input logic [11:0] i);
		return {2'b00, i, 2'b00};
	endfunction : ad
	function automatic logic [31:0] f_sel(input logic a, b, f);
		return {24'h0, a, b, 5'h00, f};
	endfunction : f_sel
	function automatic logic [31:0] f_cap(input logic [11:0] i,
		input logic [9:0][7:0] o);
		case (i)
		rtc_pkg::IDX_DEV_ID: return {24'h0, o[0]};
		rtc_pkg::IDX_BANK_ID: return {28'h0, o[1][3:0]};
		rtc_pkg::IDX_LANE_ADJ: return {24'h0, o[2] & 8'h7f};
		rtc_pkg::IDX_SCR_LANES: return {24'h0, o[3] & 8'h9f};
		default: return {24'h0, o[9][7:5], 5'h00};
		endcase
	endfunction : f_cap

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// One APB transfer; holds the request until ready is seen high.
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk("pready", 1'b1, pready);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb

	task flag(input logic f);
		apb(1'b0, ad(rtc_pkg::IDX_SEL_RESULT), 32'h0);
		chk("result", f_sel(l, p, f), rd);
	endtask : flag

	task summarize;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize

	// Watchdog: far beyond the thousand or so cycles the tests need.
	initial begin
		#3000000;
		mismatches++;
		summarize();
	end

	// ==========================================================
	// Main sequence.
	initial begin
		seed = 37;
		{clk, rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hf;
		rw_idx = '{rtc_pkg::IDX_LINK_PAGE, rtc_pkg::IDX_CHECK_CTRL,
			rtc_pkg::IDX_REF_LOW, rtc_pkg::IDX_REF_HIGH,
			rtc_pkg::IDX_SEL_RESULT, rtc_pkg::IDX_LANE_INV};
		rw_msk = '{8'h01, 8'hff, 8'hff, 8'hff, 8'hc0, 8'hff};
		cap_idx = '{rtc_pkg::IDX_DEV_ID, rtc_pkg::IDX_BANK_ID,
			rtc_pkg::IDX_LANE_ADJ, rtc_pkg::IDX_SCR_LANES, rtc_pkg::IDX_VERSION};
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values, refusals and read-write access.
		for (k = 0; k < 6; k++) begin
			apb(1'b0, ad(rw_idx[k]), 32'h0);
			chk("reset rw", 32'h0, rd);
			m = 8'($random(seed));
			apb(1'b1, ad(rw_idx[k]), {24'h0, m});
			apb(1'b0, ad(rw_idx[k]), 32'h0);
			chk("readback", {24'h0, m & rw_msk[k]}, rd);
		end
		for (k = 0; k < 5; k++) begin
			apb(1'b0, ad(cap_idx[k]), 32'h0);
			chk("reset ro", 32'h0, rd);
		end
		apb(1'b1, ad(rtc_pkg::IDX_DEV_ID), 32'hff);
		apb(1'b0, ad(rtc_pkg::IDX_DEV_ID), 32'h0);
		chk("ro write", 32'h0, rd);
		apb(1'b0, ad(12'h001), 32'h0);
		chk("unmapped", 32'h1, {31'h0, er});
		apb(1'b0, ad(rtc_pkg::IDX_REF_LOW) + 16'h2, 32'h0);
		chk("unaligned", 32'h1, {31'h0, er});
		pstrb <= 4'he;
		apb(1'b1, ad(rtc_pkg::IDX_LANE_INV), {24'h0, ~m});
		pstrb <= 4'hf;
		apb(1'b0, ad(rtc_pkg::IDX_LANE_INV), 32'h0);
		chk("strobe", {24'h0, m}, rd);
		$display("test registers done");
		// Lane inversion with all-clear, all-set and random masks.
		for (j = 0; j < 4; j++) begin
			m = j < 2 ? {8{j[0]}} : 8'($random(seed));
			apb(1'b1, ad(rtc_pkg::IDX_LANE_INV), {24'h0, m});
			@(negedge clk);
			li = lane_in;
			@(negedge clk);
			for (k = 0; k < 8; k++)
				chk("lane", li[k] ^ {32{m[k]}}, lane_out[k]);
		end
		$display("test lanes done");
		// Every index, subchannel, link and path, with decoys.
		for (k = 0; k < 16; k++) begin
			{l, p, c, r16} = {k[0], k[1], 2'(k % 3), 16'($random(seed))};
			apb(1'b1, ad(rtc_pkg::IDX_CHECK_CTRL), {24'h0, k[3:0], c, 2'b01});
			apb(1'b1, ad(rtc_pkg::IDX_REF_LOW), {24'h0, r16[7:0]});
			apb(1'b1, ad(rtc_pkg::IDX_REF_HIGH), {24'h0, r16[15:8]});
			apb(1'b1, ad(rtc_pkg::IDX_SEL_RESULT), {24'h0, l, p, 6'h00});
			i_rtc_tx_model.send(l, p, c, k[3:0], r16);
			for (j = 0; j < 4; j++)
				i_rtc_tx_model.send(l ^ (j == 0), p ^ (j == 1),
					j == 2 ? (c + 2'd1) % 2'd3 : c, k[3:0] + 4'(j == 3), ~r16);
			flag(1'b0);
			i_rtc_tx_model.send(l, p, c, k[3:0], r16 ^ (16'h1 << k));
			flag(1'b1);
			apb(1'b1, ad(rtc_pkg::IDX_CHECK_CTRL), {24'h0, k[3:0], c, 2'b11});
			flag(1'b0);
		end
		$display("test sample check done");
		// Disabled checker ignores samples and holds its flag.
		apb(1'b1, ad(rtc_pkg::IDX_CHECK_CTRL), 32'h00);
		i_rtc_tx_model.send(l, p, 2'd0, 4'd0, ~r16);
		flag(1'b0);
		apb(1'b1, ad(rtc_pkg::IDX_CHECK_CTRL), 32'h01);
		i_rtc_tx_model.send(l, p, 2'd0, 4'd0, ~r16);
		apb(1'b1, ad(rtc_pkg::IDX_CHECK_CTRL), 32'h00);
		i_rtc_tx_model.send(l, p, 2'd0, 4'd0, r16);
		flag(1'b1);
		apb(1'b1, ad(rtc_pkg::IDX_CHECK_CTRL), 32'h00);
		flag(1'b1);
		apb(1'b1, ad(rtc_pkg::IDX_CHECK_CTRL), 32'h02);
		flag(1'b0);
		$display("test enable done");
		// Alignment capture, one bank per link, both version codes.
		for (k = 0; k < 2; k++) begin
			for (j = 0; j < 10; j++)
				capt[k][j] = $random(seed);
			capt[k][9][7:5] = k[0] ? rtc_pkg::VER_CURRENT : rtc_pkg::VER_EARLIER;
			i_rtc_tx_model.send_ilas(k[0], capt[k]);
		end
		for (k = 0; k < 2; k++) begin
			apb(1'b1, ad(rtc_pkg::IDX_LINK_PAGE), 32'(k));
			for (j = 0; j < 5; j++) begin
				apb(1'b0, ad(cap_idx[j]), 32'h0);
				chk("capture", f_cap(cap_idx[j], capt[k]), rd);
			end
		end
		$display("test capture done");
		summarize();
	end
endmodule : rtc_top_tb
